// ---- rtl/conmc_defs.vh ----
// Constants for the node management and predefined-service block.
// Assumes inclusion by bare name from the design files under rtl/.
`ifndef CONMC_DEFS_VH
`define CONMC_DEFS_VH

// ==========================================
// Identifiers
`define CONMC_ID_NMT 11'h000
`define CONMC_ID_SYNC 11'h080
`define CONMC_ID_TIME 11'h100
`define CONMC_FC_EMCY 4'h1
`define CONMC_FC_TPDO1 4'h3
`define CONMC_FC_RPDO1 4'h4
`define CONMC_FC_TPDO2 4'h5
`define CONMC_FC_RPDO2 4'h6
`define CONMC_FC_TPDO3 4'h7
`define CONMC_FC_RPDO3 4'h8
`define CONMC_FC_TPDO4 4'h9
`define CONMC_FC_RPDO4 4'ha
`define CONMC_FC_SDO_TX 4'hb
`define CONMC_FC_SDO_RX 4'hc
`define CONMC_FC_ERRCTL 4'he

// ==========================================
// Command specifiers
`define CONMC_CS_START 8'h01
`define CONMC_CS_STOP 8'h02
`define CONMC_CS_PREOP 8'h80
`define CONMC_CS_RST_APP 8'h81
`define CONMC_CS_RST_COM 8'h82
`define CONMC_ADDR_ALL 8'h00

// ==========================================
// Node states as reported on the heartbeat
`define CONMC_HB_BOOT 8'h00
`define CONMC_HB_STOP 8'h04
`define CONMC_HB_OPER 8'h05
`define CONMC_HB_PREOP 8'h7f

// ==========================================
// Error register values
`define CONMC_ERREG_NONE 8'h00
`define CONMC_ERREG_GENERIC 8'h01
`define CONMC_ERREG_INTERNAL 8'h80
`define CONMC_EMCY_CLEAR 16'h0000

// ==========================================
// Timing
`define CONMC_CLK_MHZ 250
`define CONMC_TICK_US 1
`define CONMC_TICK_CYC (`CONMC_CLK_MHZ * `CONMC_TICK_US)
`define CONMC_TICK_W 8
`define CONMC_INIT_CYC 4'h8
`define CONMC_MS_LAST 10'h3e7

`endif

// ---- rtl/conmc_tick.v ----
// One-cycle enable pulse every CONMC_TICK_CYC core clocks (1 us tick).
// Assumes a single clock domain and an active-low asynchronous reset.
`timescale 1ns/1ps
`include "conmc_defs.vh"

module conmc_tick (
	// Clock and reset
	input wire core_clk,
	input wire rst_n,
	// Tick out
	output reg tick_reg
);
	reg [`CONMC_TICK_W-1:0] cnt_reg;
	localparam integer LAST_INT = `CONMC_TICK_CYC - 1;
	localparam [`CONMC_TICK_W-1:0] LAST = LAST_INT[`CONMC_TICK_W-1:0];

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= 8'h00;
			tick_reg <= 1'b0;
		end else if (cnt_reg == LAST) begin
			cnt_reg <= 8'h00;
			tick_reg <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 8'h01;
			tick_reg <= 1'b0;
		end
	end
endmodule // conmc_tick

// ---- rtl/conmc_node.v ----
// Node management core: state machine, service gating, boot-up,
// heartbeat, emergency and predefined identifiers for one node.
// Assumes a CAN controller delivering received frames as one-cycle
// strobes and accepting transmit requests with a done pulse.
`timescale 1ns/1ps
`include "conmc_defs.vh"

// Functional notes
// - Power-up enters initialization; afterwards moves on to pre-operational by itself.
// - Initializing steps automatically into reset-application sub-state.
// - Reset-application completes, then reset-communication sub-state follows.
// - Only the single management master commands; this node is a slave.
// - Command frame: identifier 0, byte 0 specifier, byte 1 address, 0 broadcasts.
// - Commands are executed with no acknowledgement frame sent.
// - Specifier 01 enters operational, 02 enters stopped.
// - Specifier 80 returns to pre-operational from operational or stopped.
// - Specifiers 81 and 82 re-enter initialization from any running state.
// - Process data only when operational; boot-up only from initialization.
// - Service, SYNC, time, emergency in pre-op/operational; commands also stopped.
// - No node guarding; heartbeat sent periodically at producer interval.
// - One boot-up frame on 700h plus node number after initialization.
// - SYNC on 80h; synchronous mode holds buffered commands until SYNC.
// - Error sends emergency with code, clear sends code 0 and normal.
// - Emergency at 80h plus node: code low first, register, maker bytes.
// - Error register reads 0 none, 1 generic, 80h internal.
// - Broadcast identifiers 0, 80h, 100h; top four bits are function code.
// - Process-data identifiers are base plus node number.
// - Service replies 580h, requests 600h, error control 700h, plus node.
module conmc_node (
	// Clock and reset
	input wire core_clk,
	input wire rst_n,
	// Configuration
	input wire [6:0] node_id,
	input wire [15:0] hb_period_ms,
	input wire sync_mode,
	// Received frames from CAN controller
	input wire rx_valid,
	input wire [10:0] rx_id,
	input wire [3:0] rx_dlc,
	input wire [63:0] rx_data,
	// Transmit request to CAN controller
	output reg tx_valid_reg,
	output reg [10:0] tx_id_reg,
	output reg [3:0] tx_dlc_reg,
	output reg [63:0] tx_data_reg,
	input wire tx_done,
	// Application error inputs
	input wire app_err,
	input wire app_err_internal,
	input wire [15:0] app_err_code,
	input wire [39:0] app_maker_code,
	// Accepted traffic strobes to the application
	output reg pdo_rx_reg,
	output reg [1:0] pdo_num_reg,
	output reg sdo_rx_reg,
	output reg sync_rx_reg,
	output reg time_rx_reg,
	output reg cmd_apply_reg,
	// Status
	output reg [7:0] nmt_state_reg,
	output reg [7:0] err_reg_reg,
	output reg err_state_reg
);
	// ==========================================
	// State encoding
	localparam [2:0] ST_INIT = 3'h0;
	localparam [2:0] ST_RST_APP = 3'h1;
	localparam [2:0] ST_RST_COM = 3'h2;
	localparam [2:0] ST_PREOP = 3'h3;
	localparam [2:0] ST_OPER = 3'h4;
	localparam [2:0] ST_STOP = 3'h5;

	// ==========================================
	// Local signals
	reg [2:0] st_reg;
	reg [2:0] st_next;
	reg [3:0] sub_cnt_reg;
	reg boot_pend_reg;
	reg hb_pend_reg;
	reg emcy_pend_reg;
	reg [15:0] emcy_code_reg;
	reg err_seen_reg;
	reg cmd_hold_reg;
	reg tx_busy_reg;
	reg [9:0] us_cnt_reg;
	reg [15:0] ms_cnt_reg;
	reg [7:0] err_reg_next;
	wire tick;
	wire [3:0] rx_fc;
	wire [6:0] rx_node;
	wire nmt_hit;
	wire ms_tick;
	wire running;
	wire can_svc;

	conmc_tick u_tick (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.tick_reg(tick)
	);

	assign rx_fc = rx_id[10:7];
	assign rx_node = rx_id[6:0];
	assign running = (st_reg == ST_PREOP) || (st_reg == ST_OPER) || (st_reg == ST_STOP);
	assign can_svc = (st_reg == ST_PREOP) || (st_reg == ST_OPER);
	// Accepted only from the master on id 0 and for this node or all
	assign nmt_hit = rx_valid && running && (rx_id == `CONMC_ID_NMT) && (rx_dlc == 4'h2)
		&& ((rx_data[15:8] == `CONMC_ADDR_ALL) || (rx_data[15:8] == {1'b0, node_id}));

	// ==========================================
	// Node state machine
	always @* begin
		st_next = st_reg;
		case (st_reg)
			ST_INIT: begin
				if (sub_cnt_reg == `CONMC_INIT_CYC)
					st_next = ST_RST_APP;
			end
			ST_RST_APP: begin
				if (sub_cnt_reg == `CONMC_INIT_CYC)
					st_next = ST_RST_COM;
			end
			ST_RST_COM: begin
				if (sub_cnt_reg == `CONMC_INIT_CYC)
					st_next = ST_PREOP;
			end
			ST_PREOP, ST_OPER, ST_STOP: begin
				// No reply frame is built for commands
				if (nmt_hit) begin
					case (rx_data[7:0])
						`CONMC_CS_START: st_next = ST_OPER;
						`CONMC_CS_STOP: st_next = ST_STOP;
						`CONMC_CS_PREOP: st_next = ST_PREOP;
						`CONMC_CS_RST_APP: st_next = ST_RST_APP;
						`CONMC_CS_RST_COM: st_next = ST_RST_COM;
						default: st_next = st_reg;
					endcase
				end
			end
			default: st_next = ST_INIT;
		endcase
	end

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= ST_INIT;
			sub_cnt_reg <= 4'h0;
		end else begin
			st_reg <= st_next;
			if (st_next != st_reg)
				sub_cnt_reg <= 4'h0;
			else if (sub_cnt_reg != `CONMC_INIT_CYC)
				sub_cnt_reg <= sub_cnt_reg + 4'h1;
		end
	end

	// ==========================================
	// Heartbeat interval, 1 ms from the 1 us tick
	assign ms_tick = tick && (us_cnt_reg == `CONMC_MS_LAST);

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			us_cnt_reg <= 10'h000;
			ms_cnt_reg <= 16'h0000;
		end else begin
			if (tick)
				us_cnt_reg <= (us_cnt_reg == `CONMC_MS_LAST) ? 10'h000 : us_cnt_reg + 10'h001;
			// Period 0 disables the producer
			if (hb_period_ms == 16'h0000 || !running)
				ms_cnt_reg <= 16'h0000;
			else if (ms_tick)
				ms_cnt_reg <= (ms_cnt_reg >= hb_period_ms - 16'h0001) ? 16'h0000
					: ms_cnt_reg + 16'h0001;
		end
	end

	// ==========================================
	// Error register and emergency triggers
	always @* begin
		err_reg_next = `CONMC_ERREG_NONE;
		if (app_err)
			err_reg_next = app_err_internal ? `CONMC_ERREG_INTERNAL
				: `CONMC_ERREG_GENERIC;
	end

	// ==========================================
	// Pending frames and transmit arbitration
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			boot_pend_reg <= 1'b0;
			hb_pend_reg <= 1'b0;
			emcy_pend_reg <= 1'b0;
			emcy_code_reg <= 16'h0000;
			err_seen_reg <= 1'b0;
			tx_busy_reg <= 1'b0;
			tx_valid_reg <= 1'b0;
			tx_id_reg <= 11'h000;
			tx_dlc_reg <= 4'h0;
			tx_data_reg <= 64'h0;
			err_reg_reg <= 8'h00;
			err_state_reg <= 1'b0;
		end else begin
			err_reg_reg <= err_reg_next;
			// Boot-up armed only on leaving initialization
			if (st_reg == ST_RST_COM && st_next == ST_PREOP)
				boot_pend_reg <= 1'b1;
			else if (st_reg == ST_RST_APP || st_reg == ST_RST_COM)
				boot_pend_reg <= 1'b0;
			// Edge of the error input; stopped nodes queue it
			if (app_err != err_seen_reg) begin
				err_seen_reg <= app_err;
				err_state_reg <= app_err;
				emcy_pend_reg <= 1'b1;
				emcy_code_reg <= app_err ? app_err_code : `CONMC_EMCY_CLEAR;
			end
			if (tx_busy_reg) begin
				tx_valid_reg <= 1'b0;
				if (tx_done)
					tx_busy_reg <= 1'b0;
			end else if (boot_pend_reg) begin
				boot_pend_reg <= 1'b0;
				tx_busy_reg <= 1'b1;
				tx_valid_reg <= 1'b1;
				tx_id_reg <= {`CONMC_FC_ERRCTL, node_id};
				tx_dlc_reg <= 4'h1;
				tx_data_reg <= {56'h0, `CONMC_HB_BOOT};
			end else if (emcy_pend_reg && can_svc && app_err == err_seen_reg) begin
				emcy_pend_reg <= 1'b0;
				tx_busy_reg <= 1'b1;
				tx_valid_reg <= 1'b1;
				tx_id_reg <= {`CONMC_FC_EMCY, node_id};
				tx_dlc_reg <= 4'h8;
				tx_data_reg <= {app_maker_code, err_reg_next,
					emcy_code_reg[15:8], emcy_code_reg[7:0]};
			end else if (hb_pend_reg) begin
				hb_pend_reg <= 1'b0;
				tx_busy_reg <= 1'b1;
				tx_valid_reg <= 1'b1;
				tx_id_reg <= {`CONMC_FC_ERRCTL, node_id};
				tx_dlc_reg <= 4'h1;
				tx_data_reg <= {56'h0, nmt_state_reg};
			end
			// Set after the send so a new period is never lost
			if (ms_tick && running && hb_period_ms != 16'h0000
				&& ms_cnt_reg >= hb_period_ms - 16'h0001)
				hb_pend_reg <= 1'b1;
		end
	end

	// ==========================================
	// Receive gating and SYNC-deferred command release
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pdo_rx_reg <= 1'b0;
			pdo_num_reg <= 2'h0;
			sdo_rx_reg <= 1'b0;
			sync_rx_reg <= 1'b0;
			time_rx_reg <= 1'b0;
			cmd_apply_reg <= 1'b0;
			cmd_hold_reg <= 1'b0;
			nmt_state_reg <= `CONMC_HB_BOOT;
		end else begin
			pdo_rx_reg <= 1'b0;
			sdo_rx_reg <= 1'b0;
			sync_rx_reg <= 1'b0;
			time_rx_reg <= 1'b0;
			cmd_apply_reg <= 1'b0;
			if (rx_valid && st_reg == ST_OPER && rx_node == node_id) begin
				case (rx_fc)
					`CONMC_FC_RPDO1: begin pdo_rx_reg <= 1'b1; pdo_num_reg <= 2'h0; end
					`CONMC_FC_RPDO2: begin pdo_rx_reg <= 1'b1; pdo_num_reg <= 2'h1; end
					`CONMC_FC_RPDO3: begin pdo_rx_reg <= 1'b1; pdo_num_reg <= 2'h2; end
					`CONMC_FC_RPDO4: begin pdo_rx_reg <= 1'b1; pdo_num_reg <= 2'h3; end
					default: pdo_rx_reg <= 1'b0;
				endcase
			end
			if (rx_valid && can_svc && rx_fc == `CONMC_FC_SDO_RX && rx_node == node_id)
				sdo_rx_reg <= 1'b1;
			if (rx_valid && can_svc && rx_id == `CONMC_ID_TIME)
				time_rx_reg <= 1'b1;
			if (rx_valid && can_svc && rx_id == `CONMC_ID_SYNC)
				sync_rx_reg <= 1'b1;
			// Buffered process commands released at once or on SYNC
			if (pdo_rx_reg && !sync_mode)
				cmd_apply_reg <= 1'b1;
			else if (pdo_rx_reg)
				cmd_hold_reg <= 1'b1;
			if (sync_mode && cmd_hold_reg && rx_valid && can_svc
				&& rx_id == `CONMC_ID_SYNC) begin
				cmd_apply_reg <= 1'b1;
				cmd_hold_reg <= 1'b0;
			end
			if (st_reg != ST_OPER && st_reg != ST_PREOP)
				cmd_hold_reg <= 1'b0;
			case (st_next)
				ST_PREOP: nmt_state_reg <= `CONMC_HB_PREOP;
				ST_OPER: nmt_state_reg <= `CONMC_HB_OPER;
				ST_STOP: nmt_state_reg <= `CONMC_HB_STOP;
				default: nmt_state_reg <= `CONMC_HB_BOOT;
			endcase
		end
	end
endmodule // conmc_node

// ---- sim/conmc_monitor.sv ----
// Checker for the node management core.
// Assumes a bind onto conmc_node, one clock domain.
`timescale 1ns/1ps
module conmc_monitor (
	// Clock and reset
	input wire core_clk,
	input wire rst_n,
	// Inputs
	input wire [6:0] node_id,
	input wire rx_valid,
	input wire [10:0] rx_id,
	input wire [3:0] rx_dlc,
	input wire [63:0] rx_data,
	input wire app_err,
	input wire app_err_internal,
	// Outputs
	input wire tx_valid_reg,
	input wire [10:0] tx_id_reg,
	input wire [3:0] tx_dlc_reg,
	input wire [63:0] tx_data_reg,
	input wire pdo_rx_reg,
	input wire sdo_rx_reg,
	input wire sync_rx_reg,
	input wire time_rx_reg,
	input wire [7:0] nmt_state_reg,
	input wire [7:0] err_reg_reg,
	input wire err_state_reg
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	// ====================
	// Command decode
	wire [7:0] cs = rx_data[7:0];
	wire [7:0] adr = rx_data[15:8];
	wire nmt = rx_valid && rx_id == 11'h000 && nmt_state_reg != 8'h00;
	wire cmd = nmt && rx_dlc == 4'h2 && (adr == 8'h00 || adr == {1'b0, node_id});
	// ====================
	// Rules
	a_start_to_oper: assert property (cmd && cs == 8'h01
		|=> nmt_state_reg == 8'h05) else $error("bad start");
	a_stop_to_stopped: assert property (cmd && cs == 8'h02
		|=> nmt_state_reg == 8'h04) else $error("bad stop");
	a_preop_return: assert property (cmd && cs == 8'h80
		|=> nmt_state_reg == 8'h7f) else $error("bad preop");
	a_reset_to_init: assert property (cmd && (cs == 8'h81 || cs == 8'h82)
		|=> nmt_state_reg == 8'h00) else $error("bad reset");
	a_foreign_ignored: assert property (nmt && adr != 8'h00 && adr != {1'b0, node_id}
		|=> $stable(nmt_state_reg)) else $error("foreign command obeyed");
	a_pdo_gated: assert property (pdo_rx_reg
		|-> $past(nmt_state_reg) == 8'h05) else $error("pdo in wrong state");
	a_svc_gated: assert property (sdo_rx_reg || sync_rx_reg || time_rx_reg
		|-> $past(nmt_state_reg) == 8'h7f || $past(nmt_state_reg) == 8'h05)
		else $error("service in wrong state");
	a_boot_frame: assert property (nmt_state_reg == 8'h7f && $past(nmt_state_reg) == 8'h00
		|-> ##[1:40] tx_valid_reg && tx_id_reg == {4'he, node_id}) else $error("no boot frame");
	a_emcy_frame: assert property (tx_valid_reg && tx_id_reg[10:7] == 4'h1
		|-> tx_id_reg[6:0] == node_id && tx_dlc_reg == 4'h8 && tx_data_reg[23:16] == err_reg_reg)
		else $error("bad emergency frame");
	a_err_raise: assert property (app_err && !$past(app_err)
		|=> err_state_reg && err_reg_reg == ($past(app_err_internal) ? 8'h80 : 8'h01))
		else $error("bad error register");
	a_init_walk: assert property ($rose(rst_n)
		|-> nmt_state_reg == 8'h00 [*8] ##[12:32] nmt_state_reg == 8'h7f) else $error("bad init");
	c_emcy: cover property (tx_valid_reg && tx_id_reg[10:7] == 4'h1);
	c_pdo: cover property (pdo_rx_reg);
	c_stop: cover property (nmt_state_reg == 8'h04);
endmodule // conmc_monitor

bind conmc_node conmc_monitor u_mon (.core_clk, .rst_n, .node_id, .rx_valid, .rx_id, .rx_dlc,
	.rx_data, .app_err, .app_err_internal, .tx_valid_reg, .tx_id_reg, .tx_dlc_reg, .tx_data_reg,
	.pdo_rx_reg, .sdo_rx_reg, .sync_rx_reg, .time_rx_reg, .nmt_state_reg, .err_reg_reg,
	.err_state_reg);

// ---- sim/conmc_can_model.sv ----
// Partner: CAN controller with the network master behind it.
// Assumes the bench calls send() and sets the done latency.
`timescale 1ns/1ps
module conmc_can_model (
	// Clock and reset
	input wire core_clk,
	input wire rst_n,
	// Frames to the node
	output reg rx_valid,
	output reg [10:0] rx_id,
	output reg [3:0] rx_dlc,
	output reg [63:0] rx_data,
	// Frames from the node
	input wire tx_valid_reg,
	output reg tx_done,
	input wire [3:0] lat
);
	reg [3:0] wait_reg;
	reg busy_reg;
	// Heartbeat consumer; any frame from the node counts as a sign of life
	localparam [31:0] HB_TIMEOUT_CYC = 32'h000493e0;
	reg [31:0] hb_cnt_reg;
	reg hb_lost;
	initial begin
		rx_valid = 1'b0;
		rx_id = 11'h000;
		rx_dlc = 4'h0;
		rx_data = 64'h0;
	end
	// ====================
	// One frame; id 0 with two bytes is a master command
	task send(input [10:0] id, input [3:0] dlc, input [63:0] d);
		begin
			@(posedge core_clk);
			#1;
			rx_valid = 1'b1;
			rx_id = id;
			rx_dlc = dlc;
			rx_data = d;
			@(posedge core_clk);
			#1;
			rx_valid = 1'b0;
			rx_id = ~id;
			rx_data = ~d;
		end
	endtask
	// ====================
	// Done after a variable delay, slow sends included
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_reg <= 1'b0;
			wait_reg <= 4'h0;
			tx_done <= 1'b0;
			hb_cnt_reg <= 32'h0;
			hb_lost <= 1'b0;
		end else begin
			tx_done <= 1'b0;
			if (tx_valid_reg)
				hb_cnt_reg <= 32'h0;
			else if (hb_cnt_reg == HB_TIMEOUT_CYC)
				hb_lost <= 1'b1;
			else
				hb_cnt_reg <= hb_cnt_reg + 32'h1;
			if (tx_valid_reg) begin
				busy_reg <= 1'b1;
				wait_reg <= lat;
			end else if (busy_reg && wait_reg == 4'h0) begin
				busy_reg <= 1'b0;
				tx_done <= 1'b1;
			end else if (busy_reg) begin
				wait_reg <= wait_reg - 4'h1;
			end
		end
	end
endmodule // conmc_can_model

// ---- sim/tb.sv ----
// Bench: random and directed frames into the node management core.
// Assumes the partner model and the bound checker.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
	n_tests = n_tests + 1; \
	if ((g) !== (e)) begin \
		failures = failures + 1; \
		$display("unexpected %s exp %h got %h", nm, e, g); \
	end \
end
module tb;
	reg core_clk, rst_n, sync_mode, app_err, app_err_internal;
	reg [6:0] node_id;
	reg [15:0] app_err_code;
	reg [39:0] app_maker_code;
	reg [3:0] lat;
	wire rx_valid, tx_valid_reg, tx_done, pdo_rx_reg, sdo_rx_reg, sync_rx_reg, time_rx_reg;
	wire cmd_apply_reg, err_state_reg;
	wire [10:0] rx_id, tx_id_reg;
	wire [3:0] rx_dlc, tx_dlc_reg;
	wire [63:0] rx_data, tx_data_reg;
	wire [1:0] pdo_num_reg;
	wire [7:0] nmt_state_reg, err_reg_reg;
	integer failures, n_tests, cyc, i, j;
	reg [31:0] seed;
	reg [7:0] st, adr;
	reg [78:0] exp;
	conmc_can_model can (.core_clk, .rst_n, .rx_valid, .rx_id, .rx_dlc, .rx_data,
		.tx_valid_reg, .tx_done, .lat);
	conmc_node uut (.core_clk, .rst_n, .node_id, .hb_period_ms(16'h0001), .sync_mode,
		.rx_valid, .rx_id, .rx_dlc, .rx_data, .tx_valid_reg, .tx_id_reg, .tx_dlc_reg,
		.tx_data_reg, .tx_done, .app_err, .app_err_internal, .app_err_code, .app_maker_code,
		.pdo_rx_reg, .pdo_num_reg, .sdo_rx_reg, .sync_rx_reg, .time_rx_reg, .cmd_apply_reg,
		.nmt_state_reg, .err_reg_reg, .err_state_reg);
	function [31:0] lfsr_next(input [31:0] v);
		lfsr_next = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	function [7:0] next_st(input [7:0] s, input [7:0] c);
		case (c)
			8'h01: next_st = 8'h05;
			8'h02: next_st = 8'h04;
			8'h80: next_st = 8'h7f;
			8'h81, 8'h82: next_st = 8'h00;
			default: next_st = s;
		endcase
	endfunction
	task print_verdict;
		begin
			$display("checks %0d mismatches %0d", n_tests, failures);
			if (failures == 0 && n_tests > 0)
				$display("Test passed");
			else
				$display("Test failed");
			$finish;
		end
	endtask
	task wait_tx;
		begin
			@(posedge core_clk);
			#1;
			for (cyc = cyc; tx_valid_reg !== 1'b1 && cyc < 5000; cyc = cyc) begin
				@(posedge core_clk);
				#1;
			end
		end
	endtask
	task wait_boot;
		begin
			wait_tx;
			`CHK("boot id", {4'he, node_id}, tx_id_reg)
			`CHK("boot data", 12'h100, {tx_dlc_reg, tx_data_reg[7:0]})
			`CHK("preop", 8'h7f, nmt_state_reg)
			st = 8'h7f;
		end
	endtask
	task nmt(input [7:0] c, input [7:0] a);
		begin
			can.send(11'h000, 4'h2, {seed, 16'h0, a, c});
			if (a[7] == 1'b0)
				st = next_st(st, c);
			`CHK("state", st, nmt_state_reg)
		end
	endtask
	task svc_check(input [1:0] n);
		begin
			can.send({4'h4 + {n, 1'b0}, node_id}, 4'h8, {seed, seed});
			`CHK("pdo", st == 8'h05, pdo_rx_reg)
			if (st == 8'h05) `CHK("pdo num", n, pdo_num_reg)
			can.send({4'hc, node_id}, 4'h8, {seed, seed});
			`CHK("sdo", st == 8'h7f || st == 8'h05, sdo_rx_reg)
			can.send(11'h080, 4'h0, 64'h0);
			`CHK("sync", st == 8'h7f || st == 8'h05, sync_rx_reg)
			can.send(11'h100, 4'h6, {seed, seed});
			`CHK("time", st == 8'h7f || st == 8'h05, time_rx_reg)
		end
	endtask
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc = cyc + 1;
		if (cyc == 5000) begin
			failures = failures + 1;
			print_verdict;
		end
	end
	initial begin
		failures = 0;
		n_tests = 0;
		cyc = 0;
		seed = 32'h3822;
		node_id = (seed[6:0] == 7'h00) ? 7'h01 : seed[6:0];
		{sync_mode, app_err, app_err_internal, app_err_code, app_maker_code} = 59'h0;
		lat = 4'h3;
		st = 8'h00;
		rst_n = 1'b0;
		repeat (5) @(posedge core_clk);
		#1;
		rst_n = 1'b1;
		wait_boot;
		$display("boot test done");
		for (i = 0; i < 16; i = i + 1) begin
			seed = lfsr_next(seed);
			lat = seed[15:12];
			adr = seed[3] ? {1'b1, seed[10:4]} : (seed[2] ? {1'b0, node_id} : 8'h00);
			nmt(seed[1] ? 8'h80 : (seed[0] ? 8'h02 : 8'h01), adr);
			svc_check(seed[12:11]);
		end
		nmt(8'h33, 8'h00);
		can.send(11'h000, 4'h3, {48'h0, 8'h00, 8'h02});
		`CHK("bad dlc", st, nmt_state_reg)
		$display("command test done");
		nmt(8'h01, 8'h00);
		for (j = 0; j < 2; j = j + 1) begin
			seed = lfsr_next(seed);
			{app_err_code, app_maker_code} = {seed[23:0], seed};
			app_err_internal = j[0];
			app_err = 1'b1;
			wait_tx;
			exp = {4'h1, node_id, 4'h8, app_maker_code, j[0] ? 8'h80 : 8'h01, app_err_code};
			`CHK("emcy", exp, {tx_id_reg, tx_dlc_reg, tx_data_reg})
			`CHK("err state", 1'b1, err_state_reg)
			`CHK("err reg", j[0] ? 8'h80 : 8'h01, err_reg_reg)
			app_err = 1'b0;
			wait_tx;
			exp = {4'h1, node_id, 4'h8, app_maker_code, 24'h0};
			`CHK("emcy clear", exp, {tx_id_reg, tx_dlc_reg, tx_data_reg})
			`CHK("err normal", 1'b0, err_state_reg)
		end
		$display("emergency test done");
		sync_mode = 1'b1;
		can.send({4'h4, node_id}, 4'h8, {seed, seed});
		@(posedge core_clk);
		#1;
		`CHK("held", 1'b0, cmd_apply_reg)
		can.send(11'h080, 4'h0, 64'h0);
		for (i = 0; i < 4 && cmd_apply_reg !== 1'b1; i = i + 1) begin
			@(posedge core_clk);
			#1;
		end
		`CHK("apply", 1'b1, cmd_apply_reg)
		$display("sync test done");
		nmt(8'h81, {1'b0, node_id});
		wait_boot;
		nmt(8'h82, 8'h00);
		wait_boot;
		$display("reset test done");
		`CHK("hb lost", 1'b0, can.hb_lost)
		print_verdict;
	end
endmodule // tb
